// [inc/icc_defines.vh]
// constants for the input capture control block: offsets, fields, resets, codes
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register
//
// Contract
// [R1] stop-in-idle set halts channel during idle
// [R2] timebase select picks captured counter source
// [R3] captures per interrupt: one to four
// [R4] overflow flag set on capture overflow
// [R5] buffer-not-empty reads one while data waits
// [R6] unimplemented control bits read zero, ignore writes
// [R7] software routes input pin before use
// [R8] mode field selects edge and prescale behaviour
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH
`define ICC_OFF_CTRL 4'h0
`define ICC_OFF_BUF 4'h4
`define ICC_OFF_STAT 4'h8
`define ICC_OFF_MASK 4'hC
`define ICC_CTRL_RESET 16'h0000
`define ICC_CTRL_WMASK 16'h3C67
`define ICC_BIT_SIDL 13
`define ICC_TSEL_HI 12
`define ICC_TSEL_LO 10
`define ICC_CPI_HI 6
`define ICC_CPI_LO 5
`define ICC_BIT_OV 4
`define ICC_BIT_BNE 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0
`define ICC_TSEL_SYS 3'h7
`define ICC_TSEL_RSV6 3'h6
`define ICC_TSEL_RSV5 3'h5
`define ICC_TSEL_T1 3'h4
`define ICC_TSEL_T5 3'h3
`define ICC_TSEL_T4 3'h2
`define ICC_TSEL_T2 3'h1
`define ICC_TSEL_T3 3'h0
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_EVERY 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_PRE4 3'h4
`define ICC_MODE_PRE16 3'h5
`define ICC_MODE_UNUSED 3'h6
`define ICC_MODE_WAKE 3'h7
`define ICC_PRE4_LAST 2'h3
`define ICC_PRE16_LAST 4'hF
`define ICC_ST_CAPT 0
`define ICC_ST_OVF 1
`define ICC_ST_WAKE 2
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2
`endif

// [design/icc_capture_ctrl.v]
// input capture channel: control register, edge detect, prescaler, fifo, interrupts
// assumes timer values arrive synchronous to clk; the pin is asynchronous
`timescale 1ns/100ps
`include "icc_defines.vh"
module icc_capture_ctrl #(
  parameter TW = 16,
  parameter DEPTH = 4
) (
  input wire clk,
  input wire rstn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire capture_input_pin,
  input wire cpuIdle,
  input wire cpuSleep,
  input wire [TW-1:0] timer1Val,
  input wire [TW-1:0] timer2Val,
  input wire [TW-1:0] timer3Val,
  input wire [TW-1:0] timer4Val,
  input wire [TW-1:0] timer5Val,
  input wire [TW-1:0] sysClkCount,
  output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// state
reg [15:0] ctrl_r; // control word, writable fields only
reg [2:0] status_r; // sticky events: capture irq, overflow, wake
reg [2:0] mask_r; // interrupt enables, same layout
reg [2:0] pinSync_r; // three-stage pin synchroniser
reg pinLevel_r; // debounced level, second and third agree
reg [3:0] preCnt_r; // rising-edge prescaler
reg [1:0] cpiCnt_r; // captures since last interrupt
reg [TW-1:0] fifo_r [0:DEPTH-1]; // capture buffer
reg [1:0] wrPtr_r;
reg [1:0] rdPtr_r;
reg [2:0] count_r; // words held
reg ovf_r; // overflow flag
reg awHeld_r;
reg wHeld_r;
reg [3:0] awAddr_r;
reg [15:0] wData_r;
reg [1:0] wStrb_r;

wire [2:0] mode = ctrl_r[`ICC_MODE_HI:`ICC_MODE_LO];
wire [2:0] tsel = ctrl_r[`ICC_TSEL_HI:`ICC_TSEL_LO];
wire [1:0] capPerIrq = ctrl_r[`ICC_CPI_HI:`ICC_CPI_LO];
wire bufNotEmpty = (count_r != 3'h0); // [R5]
wire halted = ctrl_r[`ICC_BIT_SIDL] & cpuIdle; // [R1]

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser; first stage feeds only the second
always @(posedge clk) begin
  if (!rstn) begin
    pinSync_r <= 3'h0;
    pinLevel_r <= 1'b0;
  end else begin
    pinSync_r <= {pinSync_r[1:0], capture_input_pin};
    // change counts once stages two and three agree
    if (pinSync_r[1] == pinSync_r[2]) begin
      pinLevel_r <= pinSync_r[2];
    end
  end
end

// edge detect against the filtered level
wire riseNow = (pinSync_r[1] == pinSync_r[2]) & pinSync_r[2] & ~pinLevel_r;
wire fallNow = (pinSync_r[1] == pinSync_r[2]) & ~pinSync_r[2] & pinLevel_r;

////////////////////////////////////////////////////////////////////////////////
// timebase mux; reserved codes capture zero
function [TW-1:0] pickTime;
  input [2:0] sel;
  begin
    case (sel) // [R2]
      `ICC_TSEL_SYS: pickTime = sysClkCount;
      `ICC_TSEL_T1: pickTime = timer1Val;
      `ICC_TSEL_T5: pickTime = timer5Val;
      `ICC_TSEL_T4: pickTime = timer4Val;
      `ICC_TSEL_T2: pickTime = timer2Val;
      `ICC_TSEL_T3: pickTime = timer3Val;
      default: pickTime = {TW{1'b0}};
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// capture event decode per mode
reg captEv;
reg wakeEv;
always @* begin
  captEv = 1'b0;
  wakeEv = 1'b0;
  if (!halted) begin
    case (mode) // [R8]
      `ICC_MODE_EVERY: captEv = riseNow | fallNow;
      `ICC_MODE_FALL: captEv = fallNow;
      `ICC_MODE_RISE: captEv = riseNow;
      `ICC_MODE_PRE4: captEv = riseNow & (preCnt_r[1:0] == `ICC_PRE4_LAST);
      `ICC_MODE_PRE16: captEv = riseNow & (preCnt_r == `ICC_PRE16_LAST);
      // interrupt-pin use only while the cpu sleeps or idles
      `ICC_MODE_WAKE: wakeEv = riseNow & (cpuSleep | cpuIdle);
      default: captEv = 1'b0;
    endcase
  end
end

wire irqEv = captEv & (cpiCnt_r == capPerIrq); // [R3]
// widen the count so the compare against the integer depth keeps every bit
wire fifoFull = ({29'h0, count_r} == DEPTH);
wire pushOk = captEv & ~fifoFull;

////////////////////////////////////////////////////////////////////////////////
// axi-lite handshake decode
wire awTake = s_axi_awvalid & s_axi_awready;
wire wTake = s_axi_wvalid & s_axi_wready;
wire doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
wire arTake = s_axi_arvalid & s_axi_arready;
wire popBuf = arTake & (s_axi_araddr[3:0] == `ICC_OFF_BUF) & bufNotEmpty;
wire wrCtrl = doWrite & (awAddr_r == `ICC_OFF_CTRL);
wire wrStat = doWrite & (awAddr_r == `ICC_OFF_STAT);
wire wrMask = doWrite & (awAddr_r == `ICC_OFF_MASK);
wire [15:0] wMerged = {wStrb_r[1] ? wData_r[15:8] : ctrl_r[15:8],
  wStrb_r[0] ? wData_r[7:0] : ctrl_r[7:0]};

////////////////////////////////////////////////////////////////////////////////
// capture core: prescaler, interrupt divider, fifo, overflow
always @(posedge clk) begin
  if (!rstn) begin
    preCnt_r <= 4'h0;
    cpiCnt_r <= 2'h0;
    wrPtr_r <= 2'h0;
    rdPtr_r <= 2'h0;
    count_r <= 3'h0;
    ovf_r <= 1'b0;
  end else if (mode == `ICC_MODE_OFF || mode == `ICC_MODE_UNUSED) begin
    // disabling the module flushes buffer and overflow
    preCnt_r <= 4'h0;
    cpiCnt_r <= 2'h0;
    wrPtr_r <= 2'h0;
    rdPtr_r <= 2'h0;
    count_r <= 3'h0;
    ovf_r <= 1'b0;
  end else begin
    if (riseNow && !halted) begin
      preCnt_r <= preCnt_r + 4'h1;
    end
    if (captEv) begin
      cpiCnt_r <= (cpiCnt_r == capPerIrq) ? 2'h0 : cpiCnt_r + 2'h1;
    end
    if (pushOk) begin
      fifo_r[wrPtr_r] <= pickTime(tsel);
      wrPtr_r <= wrPtr_r + 2'h1;
    end
    if (captEv && fifoFull) begin
      ovf_r <= 1'b1; // [R4]
    end else if (popBuf) begin
      ovf_r <= 1'b0; // reading frees room, overflow clears
    end
    if (popBuf) begin
      rdPtr_r <= rdPtr_r + 2'h1;
    end
    count_r <= count_r + {2'h0, pushOk} - {2'h0, popBuf};
  end
end

////////////////////////////////////////////////////////////////////////////////
// registers: control, status (w1c, set wins), mask
always @(posedge clk) begin
  if (!rstn) begin
    ctrl_r <= `ICC_CTRL_RESET;
    status_r <= 3'h0;
    mask_r <= 3'h0;
  end else begin
    if (wrCtrl) begin
      ctrl_r <= wMerged & `ICC_CTRL_WMASK; // [R6]
    end
    if (wrMask) begin
      mask_r <= wData_r[2:0];
    end
    // clear first, then set so a same-cycle event survives
    status_r <= (status_r & ~(wrStat ? wData_r[2:0] : 3'h0))
      | {wakeEv, captEv & fifoFull, irqEv};
  end
end

////////////////////////////////////////////////////////////////////////////////
// write channel: address and data accepted in either order
always @(posedge clk) begin
  if (!rstn) begin
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `ICC_RESP_OKAY;
    awHeld_r <= 1'b0;
    wHeld_r <= 1'b0;
    awAddr_r <= 4'h0;
    wData_r <= 16'h0000;
    wStrb_r <= 2'h0;
  end else begin
    s_axi_awready <= ~awHeld_r & ~awTake;
    s_axi_wready <= ~wHeld_r & ~wTake;
    if (awTake) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr[3:0];
    end
    if (wTake) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata[15:0];
      wStrb_r <= s_axi_wstrb[1:0];
    end
    if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      // buffer is read-only, counted as ok; unmapped gets slverr
      s_axi_bresp <= (awAddr_r[1:0] == 2'h0) ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// read channel; one read at a time, buffer read pops a word
always @(posedge clk) begin
  if (!rstn) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `ICC_RESP_OKAY;
  end else begin
    s_axi_arready <= ~s_axi_rvalid & ~arTake;
    if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ICC_RESP_OKAY;
      case (s_axi_araddr[3:0])
        `ICC_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl_r[15:5], ovf_r, bufNotEmpty,
          ctrl_r[2:0]}; // [R4] [R5]
        `ICC_OFF_BUF: s_axi_rdata <= bufNotEmpty ?
          {{(32-TW){1'b0}}, fifo_r[rdPtr_r]} : 32'h00000000;
        `ICC_OFF_STAT: s_axi_rdata <= {29'h0, status_r};
        `ICC_OFF_MASK: s_axi_rdata <= {29'h0, mask_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `ICC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// level interrupt from registered status and mask
always @(posedge clk) begin
  if (!rstn) begin
    irq <= 1'b0;
  end else begin
    irq <= |(status_r & mask_r);
  end
end

endmodule // icc_capture_ctrl

// [testbench/icc_edge_source.sv]
// edge source standing on the routed capture pin
// assumes run() is called just after a clock edge
`timescale 1ns/100ps
module icc_edge_src (
  input wire clk,
  output logic pin
);
  initial pin = 1'b0; // idle low between bursts
  // n square pulses, w cycles high then w low; larger w plays a slow source
  task automatic run(input int n, input int w);
    repeat (n) begin
      pin <= 1'b1;
      repeat (w) @(posedge clk);
      pin <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask
endmodule // icc_edge_src

// [testbench/icc_capture_ctrl_chk.sv]
// bus-side checks of the capture channel
// assumes it is bound to icc_capture_ctrl and sees its ports only
`timescale 1ns/100ps
module icc_capture_ctrl_chk (
  input wire clk,
  input wire rstn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // both write halves taken at one edge
  sequence s_wt; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rt; s_axi_arvalid && s_axi_arready; endsequence
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer not held");
  property p_blat; s_wt |-> ##[1:2] s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_rlat; s_rt |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("second read accepted");
  // unused control bits always read back low
  property p_zero; s_rt and s_axi_araddr[3:0] == 4'h0 |=>
    s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[9:7] == 3'h0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_rerr; s_rt and s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2; endproperty
  a_rerr: assert property (p_rerr) else $error("odd read not refused");
  property p_werr; s_wt and s_axi_awaddr[1:0] != 2'h0 |->
    ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2); endproperty
  a_werr: assert property (p_werr) else $error("odd write not refused");
endmodule // icc_capture_ctrl_chk
bind icc_capture_ctrl icc_capture_ctrl_chk chk (.*);

// [testbench/test_input_capture_control.sv]
// bench for the capture channel: bus tasks, scenarios, verdict
// assumes the edge source drives the pin and timer values stay still
`timescale 1ns/100ps
module test_input_capture_control;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, arv = 0, idle = 0, slp = 0, brdy = 1, rrdy = 1;
  logic [31:0] awa = 0, wd = 0, ara = 0, q;
  logic [1:0] resp;
  logic [15:0] tv [6] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h7777};
  wire awr, wr, bv, arr, rv, irq, pin;
  wire [1:0] br, rr;
  wire [31:0] rd;
  int mismatches = 0, n_checks = 0, n;
  always #2.5 clk = ~clk;
  icc_edge_src src (.clk(clk), .pin(pin));
  // answer readies come from the bus tasks, which may hold them low a few cycles
  icc_capture_ctrl dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .capture_input_pin(pin),
    .cpuIdle(idle), .cpuSleep(slp), .timer1Val(tv[0]), .timer2Val(tv[1]), .timer3Val(tv[2]),
    .timer4Val(tv[3]), .timer5Val(tv[4]), .sysClkCount(tv[5]), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  // lag > 0 keeps the answer ready low for lag cycles of a waiting answer
  task automatic wr32(input logic [31:0] a, input logic [31:0] d, input int lag = 0);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= (lag == 0);
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv && brdy) begin
        resp = br;
        break;
      end
      if (bv) begin
        lag--;
        if (lag == 0) brdy <= 1'b1;
      end
    end
  endtask
  task automatic rd32(input logic [31:0] a, input int lag = 0);
    ara <= a;
    arv <= 1'b1;
    rrdy <= (lag == 0);
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv && rrdy) begin
        q = rd;
        resp = rr;
        break;
      end
      if (rv) begin
        lag--;
        if (lag == 0) rrdy <= 1'b1;
      end
    end
  endtask
  task automatic pulse(input int k);
    src.run(k, 4);
    repeat (8) @(posedge clk);
  endtask
  // pop the buffer while it reports data waiting
  task automatic drain;
    n = 0;
    repeat (6) begin
      rd32(32'h0);
      if (q[3] !== 1'b1) break;
      rd32(32'h4);
      n++;
    end
  endtask
  task automatic t_regs;
    rd32(32'h0, 2); chk(q, 32'h0);
    chk(irq, 32'h0);
    wr32(32'h0, 32'hFFFFFFFF); rd32(32'h0); chk(q, 32'h3C67);
    wr32(32'h0, 32'h0, 2);
    wr32(32'h2, 32'h1); chk(resp, 32'h2);
    rd32(32'h6); chk(resp, 32'h2);
    $display("registers done");
  endtask
  task automatic t_tsel;
    logic [15:0] ex [8] = '{tv[2], tv[1], tv[3], tv[4], tv[0], 16'h0, 16'h0, tv[5]};
    for (int s = 0; s < 8; s++) begin
      wr32(32'h0, (32'(s) << 10) | 32'h3);
      pulse(1);
      rd32(32'h4); chk(q, {16'h0, ex[s]});
      wr32(32'h0, 32'h0);
    end
    $display("timebase done");
  endtask
  task automatic t_cpi;
    // captures of earlier tests left status set; start clean
    wr32(32'h8, 32'h7);
    wr32(32'hC, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr32(32'h0, (32'(i) << 5) | 32'h3);
      pulse(i); chk(irq, 32'h0);
      pulse(1); chk(irq, 32'h1);
      wr32(32'h0, 32'h0);
      wr32(32'h8, 32'h7);
    end
    $display("per-interrupt done");
  endtask
  task automatic t_ovf;
    wr32(32'hC, 32'h0);
    wr32(32'h0, 32'h3);
    pulse(5); rd32(32'h0); chk(q[4:3], 32'h3);
    chk(irq, 32'h0);
    wr32(32'hC, 32'h2);
    // irq follows the new mask one edge after the write answer
    @(posedge clk);
    chk(irq, 32'h1);
    wr32(32'h8, 32'h2); rd32(32'h4); chk(irq, 32'h0);
    rd32(32'h0); chk(q[4], 32'h0);
    wr32(32'h0, 32'h0); rd32(32'h0); chk(q[3], 32'h0);
    $display("overflow done");
  endtask
  task automatic t_modes;
    int np [7] = '{3, 2, 3, 3, 8, 16, 3};
    int nc [7] = '{0, 4, 3, 3, 2, 1, 0};
    for (int m = 0; m < 7; m++) begin
      wr32(32'h0, 32'(m));
      pulse(np[m]); drain; chk(n, nc[m]);
      wr32(32'h0, 32'h0);
    end
    slp <= 1'b1;
    wr32(32'hC, 32'h4);
    wr32(32'h0, 32'h7);
    pulse(1); chk(irq, 32'h1);
    wr32(32'h0, 32'h0);
    wr32(32'h8, 32'h7);
    slp <= 1'b0;
    $display("modes done");
  endtask
  task automatic t_idle;
    idle <= 1'b1;
    wr32(32'h0, 32'h2003);
    pulse(2); drain; chk(n, 32'h0);
    wr32(32'h0, 32'h0);
    wr32(32'h0, 32'h3);
    pulse(2); drain; chk(n, 32'h2);
    wr32(32'h0, 32'h0);
    idle <= 1'b0;
    $display("idle done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_tsel;
    t_cpi;
    t_ovf;
    t_modes;
    t_idle;
    stop_test;
  end
  // the whole run needs about a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule // test_input_capture_control
